/* File: lcd_frame_sleep_defs.vh */
/*
 * Register map, field positions, encodings and reset values for the
 * segment display frame and sleep controller.
 * Assumes it is included by bare name from each design file that uses its macros.
 */
`ifndef LCD_FRAME_SLEEP_DEFS_VH
`define LCD_FRAME_SLEEP_DEFS_VH

// register offsets on the plain register port
`define ADDR_MAIN_CONTROL   6'h00
`define ADDR_PHASE_PRESCALE 6'h01
`define ADDR_PIXEL_BASE     6'h20
`define PIXEL_REG_COUNT     24
`define PIXEL_LAST_INDEX    5'h17

// display_main_control fields
`define CTL_ENABLE          7
`define CTL_SLEEP_HALT      6
`define CTL_WRITE_ERROR     5
`define CTL_SRC_HI          3
`define CTL_SRC_LO          2
`define CTL_MUX_HI          1
`define CTL_MUX_LO          0
`define CTL_RESET           8'h00
`define CTL_WRITE_MASK      8'hcf

// phase_prescale_reg fields
`define PS_WAVE_TYPE_B      7
`define PS_BIAS_MODE        6
`define PS_ACTIVE           5
`define PS_WRITE_ALLOWED    4
`define PS_PRESCALE_HI      3
`define PS_PRESCALE_LO      0
`define PS_RESET            8'h00

// timing source encodings
`define SRC_SYS_DIV         2'h0
`define SRC_LP_CRYSTAL      2'h1
`define SRC_LF_INTERNAL     2'h2

// common count encodings
`define MUX_STATIC          2'h0

`define SEGMENT_COUNT       46

`endif

/* File: phase_timer.v */
/*
 * Phase slot timer: divides the selected timing-source tick by the
 * prescale value plus one and emits one pulse per drive slot.
 * Assumes source ticks are one-cycle pulses synchronous to clk.
 */
`timescale 1ns/10ps
`default_nettype none

module phase_timer
(
    // clock and reset
    input  wire       clk,
    input  wire       rst_n,
    // control
    input  wire       run,
    input  wire       src_tick,
    input  wire [3:0] prescale,
    // slot pulse
    output wire       slot_pulse
);

    reg  [3:0] count;
    wire       at_end;

    assign at_end     = (count == prescale);
    assign slot_pulse = run & src_tick & at_end;

    always @(posedge clk)
    begin
        if (!rst_n || !run)
            count <= 4'h0;
        else if (src_tick)
            count <= at_end ? 4'h0 : count + 4'h1;
    end

endmodule

`default_nettype wire

/* File: pixel_store.v */
/*
 * Pixel data store: 24 byte registers, one write port, one read port,
 * and the segment row for the common being driven.
 * Assumes the caller has already decided whether a write is allowed.
 */
`timescale 1ns/10ps
`default_nettype none

`include "lcd_frame_sleep_defs.vh"

module pixel_store
(
    // clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // register access
    input  wire        wr_en,
    input  wire [4:0]  wr_index,
    input  wire [7:0]  wr_data,
    input  wire [4:0]  rd_index,
    output wire [7:0]  rd_data,
    // row fetch
    input  wire [1:0]  com_index,
    output wire [45:0] row
);

    reg [7:0] pixel [0:`PIXEL_REG_COUNT-1];
    integer   i;

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            for (i = 0; i < `PIXEL_REG_COUNT; i = i + 1)
                pixel[i] <= 8'h00;
        end
        else if (wr_en && wr_index <= `PIXEL_LAST_INDEX)
            pixel[wr_index] <= wr_data;
    end

    assign rd_data = (rd_index <= `PIXEL_LAST_INDEX) ? pixel[rd_index] : 8'h00;

    // low 24 segments live in bytes 3c..3c+2, upper 22 in bytes 12+3c..
    genvar s;
    generate
        for (s = 0; s < `SEGMENT_COUNT; s = s + 1)
        begin : g_seg
            if (s < 24)
            begin : g_lo
                localparam integer BYTE_OFS = s / 8;
                localparam integer BIT_POS  = s % 8;
                wire [4:0] idx = {3'h0, com_index} * 5'd3 + BYTE_OFS[4:0];
                assign row[s] = pixel[idx][BIT_POS];
            end
            else
            begin : g_hi
                localparam integer BYTE_OFS = (s - 24) / 8;
                localparam integer BIT_POS  = (s - 24) % 8;
                wire [4:0] idx = 5'd12 + {3'h0, com_index} * 5'd3 + BYTE_OFS[4:0];
                assign row[s] = pixel[idx][BIT_POS];
            end
        end
    endgenerate

endmodule

`default_nettype wire

/* File: lcd_frame_sleep_control.v */
/*
 * Segment display frame, write-window and sleep/shutdown control.
 * Registers sit on a plain port with read data one cycle after the
 * read strobe. Timing-source ticks and the sleep level come from the
 * surrounding chip and are synchronous to clk.
 */
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

`include "lcd_frame_sleep_defs.vh"

// How it works
// [R01] a frame starts when the first common line begins its drive slot
// [R02] frame interrupt fires once the last common row is fetched, one slot early
// [R03] firmware finishes pixel writes inside the window after the interrupt
// [R04] with type B non-static, firmware keeps pixels steady across a frame pair
// [R05] type B interrupt only after a full two-frame phase pair
// [R06] pixel write outside the window sets the write error flag and is dropped
// [R07] no frame interrupt for type A or for type B static drive
// [R08] sleep halt enable set stops the display in sleep; clear lets it run unless the source is the system divided clock
// [R09] sleep with halt enable: stop at once, all lines to ground
// [R10] enable cleared: finish frame, drop active flag, pulse interrupt
// [R11] firmware clears enable and waits for active low before sleeping
// [R12] sleep on system divided source without halt: freeze last pattern
// [R13] sleep on low-frequency source without halt: keep running, refuse writes
// [R14] in sleep with interrupts enabled and type B non-static drive, wake at the next frame boundary
// [R15] display runs in sleep only with halt clear and a low-frequency source
// [R16] once shutdown completes, pins go back to port use
// [R17] firmware configures prescale, pins, control, pixels, interrupt, bias, enable
// [R18] firmware disables by writing zero to the whole main control register
// [R19] common select: 0 static, 1 two, 2 three, 3 four commons
// [R20] display interrupt pulses when the active flag falls
// [R21] type A flips phase inside each common, type B at each frame boundary
// [R22] write allowed status reads high only inside the permitted window
module lcd_frame_sleep_control
(
    // clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // register port
    input  wire [5:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    // timing source ticks and core state
    input  wire        sys_div_tick,
    input  wire        lp_crystal_tick,
    input  wire        lf_internal_tick,
    input  wire        sleep_active,
    input  wire        display_irq_enable,
    // events to the core
    output reg         display_irq_pulse,
    output reg         wake_request,
    // glass drive
    output reg  [3:0]  com_level,
    output reg  [45:0] seg_level,
    output reg         drive_phase,
    output reg         drive_ground,
    output reg         pins_display
);

    localparam ST_OFF   = 3'b001;
    localparam ST_RUN   = 3'b010;
    localparam ST_DRAIN = 3'b100;

    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg  [7:0]  main_control;
    reg  [7:0]  prescale_reg;
    reg         active;
    reg  [1:0]  com_index;
    reg         half_slot;
    reg         odd_frame;
    reg         window_open;

    wire        enable_bit  = main_control[`CTL_ENABLE];
    wire        sleep_halt  = main_control[`CTL_SLEEP_HALT];
    wire [1:0]  source_sel  = main_control[`CTL_SRC_HI:`CTL_SRC_LO];
    wire [1:0]  common_sel  = main_control[`CTL_MUX_HI:`CTL_MUX_LO];
    wire        type_b      = prescale_reg[`PS_WAVE_TYPE_B];
    wire [3:0]  prescale    = prescale_reg[`PS_PRESCALE_HI:`PS_PRESCALE_LO];

    wire        src_tick;
    wire        slot_pulse;
    wire        sleep_ground;
    wire        sleep_frozen;
    wire        running;
    wire        step;
    wire        last_slot;
    wire        last_com;
    wire        frame_wrap;
    wire        irq_mode;
    wire        frame_irq;
    wire        write_ok;
    wire        pixel_hit;
    wire        pixel_wr;
    wire        pixel_err;
    wire [4:0]  pixel_index;
    wire [7:0]  pixel_rdata;
    wire [45:0] row;

    assign src_tick = (source_sel == `SRC_SYS_DIV)    ? sys_div_tick :
                      (source_sel == `SRC_LP_CRYSTAL) ? lp_crystal_tick :
                                                        lf_internal_tick;

    // only halt clear plus a low-frequency source keeps running in sleep
    // freezing on the divided system clock leaves a dc pattern on the glass;
    // firmware must shut down first, the logic cannot prevent it
    assign sleep_ground = sleep_active & sleep_halt;                       // see [R09]
    assign sleep_frozen = sleep_active & ~sleep_halt
                        & (source_sel == `SRC_SYS_DIV);                    // see [R12]
    assign running      = (state != ST_OFF) & ~sleep_ground & ~sleep_frozen; // see [R08] [R15]

    phase_timer u_phase_timer
    (
        .clk        (clk),
        .rst_n      (rst_n),
        .run        (running),
        .src_tick   (src_tick),
        .prescale   (prescale),
        .slot_pulse (slot_pulse)
    );

    // type A spends two half slots per common, type B one
    assign step       = slot_pulse;
    assign last_slot  = type_b | half_slot;                                // see [R21]
    assign last_com   = (com_index == common_sel);                         // see [R19]
    assign frame_wrap = step & last_slot & last_com;                       // see [R01]

    // interrupt when the step lands on the last common: its row is the
    // final fetch of the frame, so the lead time is one common slot
    assign irq_mode  = type_b & (common_sel != `MUX_STATIC);               // see [R07]
    assign frame_irq = irq_mode & (state == ST_RUN) & step & last_slot
                     & (com_index + 2'h1 == common_sel)
                     & odd_frame;                                          // see [R02] [R05]

    // writes are free unless the pair discipline applies; sleep locks them
    assign write_ok    = (~irq_mode | window_open) & ~sleep_active;        // see [R13] [R22]
    // unmapped pixel addresses are neither stored nor flagged
    assign pixel_hit   = reg_wr & (reg_addr >= `ADDR_PIXEL_BASE)
                       & (pixel_index <= `PIXEL_LAST_INDEX);
    assign pixel_index = reg_addr[4:0];
    assign pixel_wr    = pixel_hit & write_ok;
    assign pixel_err   = pixel_hit & ~write_ok;                            // see [R06]

    pixel_store u_pixel_store
    (
        .clk       (clk),
        .rst_n     (rst_n),
        .wr_en     (pixel_wr),
        .wr_index  (pixel_index),
        .wr_data   (reg_wdata),
        .rd_index  (pixel_index),
        .rd_data   (pixel_rdata),
        .com_index (com_index),
        .row       (row)
    );

    // a cleared enable only takes effect at the next frame wrap
    always @*
    begin
        next_state = state;
        case (state)
            ST_OFF:
            begin
                if (enable_bit)
                    next_state = ST_RUN;
            end
            ST_RUN:
            begin
                if (!enable_bit)
                    next_state = ST_DRAIN;
            end
            ST_DRAIN:
            begin
                if (frame_wrap)
                    next_state = ST_OFF;                                   // see [R10]
            end
            default:
                next_state = ST_OFF;
        endcase
    end

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            state        <= ST_OFF;
            active       <= 1'b0;
            main_control <= `CTL_RESET;
            prescale_reg <= `PS_RESET;
        end
        else
        begin
            state  <= next_state;
            active <= (next_state != ST_OFF);
            // write error is sticky: a zero clears it, a one keeps it
            if (reg_wr && reg_addr == `ADDR_MAIN_CONTROL)
                main_control <= (reg_wdata & `CTL_WRITE_MASK)
                              | {2'h0, (reg_wdata[`CTL_WRITE_ERROR] & main_control[`CTL_WRITE_ERROR])
                                       | pixel_err, 5'h00};
            else if (pixel_err)
                main_control[`CTL_WRITE_ERROR] <= 1'b1;                    // see [R06]
            // active and write-allowed bits are live status, never stored
            if (reg_wr && reg_addr == `ADDR_PHASE_PRESCALE)
                prescale_reg <= {reg_wdata[7:6], 2'h0, reg_wdata[3:0]};
        end
    end

    // slot counters; cleared while off so every frame opens on common 0
    always @(posedge clk)
    begin
        if (!rst_n || state == ST_OFF)
        begin
            com_index   <= 2'h0;
            half_slot   <= 1'b0;
            odd_frame   <= 1'b0;
            window_open <= 1'b0;
        end
        else
        begin
            if (step)
            begin
                half_slot <= ~last_slot;
                if (last_slot)
                    com_index <= last_com ? 2'h0 : com_index + 2'h1;
            end
            if (frame_wrap)
                odd_frame <= ~odd_frame;                                   // see [R21]
            if (frame_irq)
                window_open <= 1'b1;                                       // see [R22]
            else if (frame_wrap)
                window_open <= 1'b0;
        end
    end

    // glass drive; left untouched while frozen, grounded on halt sleep
    always @(posedge clk)
    begin
        if (!rst_n || state == ST_OFF)
        begin
            com_level    <= 4'h0;
            seg_level    <= 46'h0;
            drive_phase  <= 1'b0;
            drive_ground <= 1'b0;
            pins_display <= 1'b0;                                          // see [R16]
        end
        else if (sleep_ground)
        begin
            com_level    <= 4'h0;
            seg_level    <= 46'h0;
            drive_phase  <= 1'b0;
            drive_ground <= 1'b1;                                          // see [R09]
            pins_display <= 1'b1;
        end
        else if (!sleep_frozen)
        begin
            com_level    <= 4'h1 << com_index;
            seg_level    <= row;
            drive_phase  <= type_b ? odd_frame : half_slot;
            drive_ground <= 1'b0;
            pins_display <= 1'b1;
        end
    end

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            display_irq_pulse <= 1'b0;
            wake_request      <= 1'b0;
        end
        else
        begin
            // shutdown pulse leaves with the drain state, as active falls
            display_irq_pulse <= frame_irq | (active & next_state == ST_OFF); // see [R20] [R10]
            wake_request      <= sleep_active & display_irq_enable
                               & irq_mode & frame_wrap;                    // see [R14]
        end
    end

    always @(posedge clk)
    begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        // read data stand for one cycle only, zero otherwise
        else if (reg_rd)
        begin
            if (reg_addr == `ADDR_MAIN_CONTROL)
                reg_rdata <= main_control;
            else if (reg_addr == `ADDR_PHASE_PRESCALE)
                reg_rdata <= {prescale_reg[7:6], active, write_ok, prescale_reg[3:0]};
            else if (reg_addr >= `ADDR_PIXEL_BASE)
                reg_rdata <= pixel_rdata;
            else
                reg_rdata <= 8'h00;
        end
        else
            reg_rdata <= 8'h00;
    end

endmodule

`default_nettype wire

/* File: lcd_glass_model.sv */
/*
 * Glass panel model: watches the common drive, ground and pin flags and counts
 * display frames.
 * Assumes registered drive outputs synchronous to clk.
 */
`timescale 1ns/10ps
`default_nettype none

module lcd_glass_model
(
    // clock
    input  wire logic        clk,
    // glass drive
    input  wire logic [3:0]  com_level,
    input  wire logic        drive_ground,
    input  wire logic        pins_display,
    // frames seen
    output var  logic [15:0] frames
);
    logic first_common_line_was = 1'b0;

    initial frames = 16'h0000;

    // grounded glass carries no common pulse, so it never counts a frame
    always @(posedge clk)
    begin
        first_common_line_was <= com_level[0];
        if (pins_display === 1'b1 && drive_ground === 1'b0 && com_level[0] === 1'b1
            && first_common_line_was === 1'b0)
            frames <= frames + 16'h0001;
    end
endmodule

`default_nettype wire

/* File: lcd_frame_sleep_control_monitor.sv */
/*
 * Port checker for the frame and sleep controller.
 * Assumes it is bound into lcd_frame_sleep_control.
 */
`timescale 1ns/10ps
`default_nettype none

module lcd_frame_sleep_control_monitor
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // observed ports
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_rdata,
    input  wire logic        sleep_active,
    input  wire logic        display_irq_enable,
    input  wire logic        display_irq_pulse,
    input  wire logic        wake_request,
    input  wire logic [3:0]  com_level,
    input  wire logic [45:0] seg_level,
    input  wire logic        drive_ground,
    input  wire logic        pins_display
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_off;
        $fell(pins_display) && !sleep_active;
    endsequence
    // the shutdown pulse is launched one edge before the pins drop
    sequence s_irq_before;
        $past(display_irq_pulse);
    endsequence

    property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
    property p_onehot; com_level != 4'h0 |-> $onehot(com_level); endproperty
    property p_off_quiet; !pins_display |-> com_level == 4'h0; endproperty
    property p_gnd_zero; drive_ground |-> com_level == 4'h0 && seg_level == 46'h0; endproperty
    property p_gnd_cause; drive_ground |-> $past(sleep_active); endproperty
    property p_irq_pulse; display_irq_pulse |=> !display_irq_pulse; endproperty
    property p_shutdown; s_off |-> s_irq_before; endproperty
    property p_wake; wake_request |-> $past(sleep_active) && $past(display_irq_enable);
    endproperty

    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside its cycle");
    a_onehot: assert property (p_onehot)
        else $error("more than one common driven");
    a_off_quiet: assert property (p_off_quiet)
        else $error("common driven while pins are port");
    a_gnd_zero: assert property (p_gnd_zero)
        else $error("grounded lines not at zero");
    a_gnd_cause: assert property (p_gnd_cause)
        else $error("grounded while awake");
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("interrupt pulse too long");
    a_shutdown: assert property (p_shutdown)
        else $error("no interrupt at shutdown");
    a_wake: assert property (p_wake)
        else $error("wake without sleep or enable");
endmodule

bind lcd_frame_sleep_control lcd_frame_sleep_control_monitor u_mon
(
    .clk, .rst_n, .reg_rd, .reg_rdata, .sleep_active, .display_irq_enable,
    .display_irq_pulse, .wake_request, .com_level, .seg_level, .drive_ground,
    .pins_display
);

`default_nettype wire

/* File: lcd_frame_sleep_control_tb.sv */
/*
 * Testbench for the frame and sleep controller: register tasks and
 * scenario sequences.
 * Assumes the glass model and bound checker are compiled before it.
 */
`timescale 1ns/10ps
`default_nettype none

module lcd_frame_sleep_control_tb;
    logic        clk;
    logic        rst_n;
    logic [5:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic        tick = 1'b0;
    logic        sleep_active;
    logic        irq_en;
    logic        display_irq_pulse;
    logic        wake_request;
    logic [3:0]  com_level;
    logic [45:0] seg_level;
    logic        drive_phase;
    logic        drive_ground;
    logic        pins_display;
    logic [15:0] frames;
    logic [15:0] f0;
    logic [1:0]  tdiv = 2'h0;
    logic [7:0]  v;
    logic [3:0]  held;
    int          err_count = 0;
    int          n_compared = 0;
    int          irq_n = 0;
    int          i;

    lcd_frame_sleep_control dut
    (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sys_div_tick(tick), .lp_crystal_tick(tick), .lf_internal_tick(tick),
        .sleep_active(sleep_active), .display_irq_enable(irq_en),
        .display_irq_pulse(display_irq_pulse), .wake_request(wake_request),
        .com_level(com_level), .seg_level(seg_level), .drive_phase(drive_phase),
        .drive_ground(drive_ground), .pins_display(pins_display)
    );

    lcd_glass_model glass
    (
        .clk(clk), .com_level(com_level), .drive_ground(drive_ground),
        .pins_display(pins_display), .frames(frames)
    );

    always #5 clk = ~clk;

    // source tick every fourth cycle keeps frames short
    always @(posedge clk)
    begin
        tdiv <= tdiv + 2'h1;
        tick <= (tdiv == 2'h3);
        if (display_irq_pulse === 1'b1)
            irq_n <= irq_n + 1;
    end

    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task chk(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [5:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task wait_ev(input bit wake, input int lim);
        int k;
        k = 0;
        do
        begin
            @(posedge clk);
            #1;
            k++;
        end
        while (k < lim && (wake ? wake_request : display_irq_pulse) !== 1'b1);
        chk(k < lim, 1'b1);
        if (k >= lim)
            end_sim();
    endtask

    task sleep_set(input logic s);
        @(posedge clk);
        sleep_active <= s;
    endtask

    initial
    begin
        repeat (60000) @(posedge clk);
        err_count++;
        end_sim();
    end

    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        reg_addr = 6'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        sleep_active = 1'b0;
        irq_en = 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(6'h00);
        chk(v, 8'h00);
        wr(6'h3f, 8'h5a);
        rd(6'h3f);
        chk(v, 8'h00);
        $display("test reset done");
        wr(6'h01, 8'h01);
        wr(6'h20, 8'ha5);
        rd(6'h20);
        chk(v, 8'ha5);
        wr(6'h00, 8'h87);
        f0 = frames;
        i = irq_n;
        repeat (300) @(posedge clk);
        chk(irq_n - i, 0);
        chk(frames > f0, 1'b1);
        wr(6'h01, 8'h83);
        wr(6'h00, 8'h84);
        i = irq_n;
        repeat (300) @(posedge clk);
        chk(irq_n - i, 0);
        $display("test no frame interrupt done");
        wr(6'h00, 8'h00);
        wait_ev(1'b0, 600);
        // pins follow the state one edge after the shutdown pulse
        @(posedge clk);
        #1 chk(pins_display, 1'b0);
        rd(6'h01);
        chk(v[5], 1'b0);
        $display("test shutdown done");
        wr(6'h00, 8'h05);
        wr(6'h20, 8'h3c);
        rd(6'h00);
        chk(v, 8'h25);
        rd(6'h20);
        chk(v, 8'ha5);
        rd(6'h01);
        chk(v[4], 1'b0);
        wr(6'h00, 8'h05);
        rd(6'h00);
        chk(v, 8'h05);
        $display("test write error done");
        wr(6'h00, 8'h85);
        wait_ev(1'b0, 600);
        f0 = frames;
        chk(drive_phase, 1'b1);
        rd(6'h01);
        chk(v, 8'hb3);
        wr(6'h21, 8'hc3);
        rd(6'h21);
        chk(v, 8'hc3);
        rd(6'h00);
        chk(v, 8'h85);
        wait_ev(1'b0, 600);
        chk(frames - f0, 16'h0002);
        chk(com_level, 4'h1);
        chk(seg_level, 46'hc3a5);
        $display("test frame interrupt done");
        @(posedge clk);
        irq_en <= 1'b1;
        sleep_set(1'b1);
        wr(6'h21, 8'h00);
        wait_ev(1'b1, 600);
        rd(6'h21);
        chk(v, 8'hc3);
        rd(6'h00);
        chk(v, 8'ha5);
        sleep_set(1'b0);
        wr(6'h00, 8'h85);
        $display("test running sleep done");
        wr(6'h00, 8'hc5);
        sleep_set(1'b1);
        repeat (2) @(posedge clk);
        #1 chk(drive_ground, 1'b1);
        chk(com_level, 4'h0);
        chk(seg_level, 46'h0);
        sleep_set(1'b0);
        $display("test halt sleep done");
        wr(6'h00, 8'h81);
        repeat (40) @(posedge clk);
        sleep_set(1'b1);
        repeat (2) @(posedge clk);
        #1 held = com_level;
        repeat (64) @(posedge clk);
        #1 chk(com_level, held);
        chk(held != 4'h0, 1'b1);
        chk(drive_ground, 1'b0);
        sleep_set(1'b0);
        wr(6'h00, 8'h00);
        $display("test frozen sleep done");
        end_sim();
    end
endmodule

`default_nettype wire
